// ==== logic/port_ctl_pkg.sv ====
// constants for the port analog, slew and pin override control block
package port_ctl_pkg;
  // register addresses on the plain register port
  localparam logic [3:0] ADDR_PIN_LEVELS = 4'h0;
  localparam logic [3:0] ADDR_OUT_LATCH = 4'h1;
  localparam logic [3:0] ADDR_DIRECTION = 4'h2;
  localparam logic [3:0] ADDR_ANALOG_LOW = 4'h3;
  localparam logic [3:0] ADDR_ANALOG_HIGH = 4'h4;
  localparam logic [3:0] ADDR_SLEW = 4'h5;
  localparam logic [3:0] ADDR_PERIPH_CTL = 4'h6;
  // implemented-bit masks
  localparam logic [7:0] ANALOG_LOW_MASK = 8'hF8;
  localparam logic [7:0] ANALOG_HIGH_MASK = 8'h0F;
  localparam logic [7:0] SLEW_MASK = 8'h07;
  localparam logic [7:0] PERIPH_MASK = 8'h07;
  // values after reset
  localparam logic [7:0] ANALOG_LOW_RESET = 8'hF8;
  localparam logic [7:0] ANALOG_HIGH_RESET = 8'h0F;
  localparam logic [7:0] SLEW_RESET = 8'h07;
  localparam logic [7:0] DIRECTION_RESET = 8'hFF;
  localparam logic [7:0] LATCH_RESET = 8'h00;
  localparam logic [7:0] PERIPH_RESET = 8'h00;
  // field positions
  localparam int SLEW_PORT_A_BIT = 0;
  localparam int SLEW_PORT_B_BIT = 1;
  localparam int SLEW_PORT_C_BIT = 2;
  localparam int ANALOG_LOW_PIN_FOUR_BIT = 3;
  localparam int PERIPH_COMPARE_EN_BIT = 0;
  localparam int PERIPH_SERIAL_OUT_EN_BIT = 1;
  localparam int PERIPH_PWM_A_EN_BIT = 2;
endpackage

// ==== logic/pin_sync2.sv ====
// two-flop synchroniser for a bus of pin levels
`timescale 1ns/1ps
`default_nettype none
module pin_sync2 #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  // levels
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] stage1;

  // first stage is read only by the second stage
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      stage1 <= '0;
      sync_o <= '0;
    end else begin
      stage1 <= async_i;
      sync_o <= stage1;
    end
  end
endmodule
`default_nettype wire

// ==== logic/port_pin_control.sv ====
// port c pin control with analog select, slew rate and output overrides
//
// The address map and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module port_pin_control (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  // register port
  input wire logic [3:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // port c pins
  input wire logic [7:0] port_c_pad_i,
  output logic [7:0] port_c_pad_o,
  output logic [7:0] port_c_pad_oe_o,
  output logic port_c_slow_edges_o,
  // port a pin four, port a and port b slew, port b analog
  input wire logic port_a_pin_four_pad_i,
  output logic port_a_pin_four_in_o,
  output logic port_a_slow_edges_o,
  output logic port_a_pin_four_slow_o,
  output logic port_b_slow_edges_o,
  output logic [1:0] port_b_analog_o,
  // peripheral hookups
  input wire logic clock_output_function_i,
  input wire logic timer_osc_en_i,
  input wire logic compare_pwm_out_i,
  input wire logic pwm_channel_a_i,
  input wire logic pwm_shutdown_i,
  input wire logic serial_data_out_i,
  output logic capture_input_o,
  output logic slave_select_o,
  output logic secondary_timers_count_input_o,
  output logic analog_channel_eight_o,
  output logic analog_channel_nine_o
);
  logic [7:0] port_c_output_latch;
  logic [7:0] port_c_direction;
  logic [7:0] analog_select_low;
  logic [7:0] analog_select_high;
  logic [7:0] slew_rate_control;
  logic [7:0] periph_ctl;
  logic [7:0] pad_sync;
  logic [7:0] next_pad_o;
  logic [7:0] next_pad_oe;
  logic [7:0] port_c_analog;
  logic [7:0] port_c_pin_levels;
  logic [7:0] next_rdata;
  logic pin_four_sync;

  // pads come from outside the clock domain
  pin_sync2 #(.WIDTH(8)) u_sync_c (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .async_i(port_c_pad_i),
    .sync_o(pad_sync)
  );

  // pin four is asynchronous too; one flop alone could go metastable
  pin_sync2 #(.WIDTH(1)) u_sync_pin_four (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .async_i(port_a_pin_four_pad_i),
    .sync_o(pin_four_sync)
  );

  // per-pin analog select mapping of port c
  always_comb begin
    port_c_analog = 8'h00;
    port_c_analog[3:0] = analog_select_low[7:4];
    port_c_analog[7:6] = analog_select_high[1:0];
  end

  // digital input path, gated by analog select and oscillator
  always_comb begin
    port_c_pin_levels = pad_sync & ~port_c_analog;
    if (timer_osc_en_i) begin
      port_c_pin_levels[7:6] = 2'b00;
    end
  end

  // register writes take effect on the write edge
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      port_c_output_latch <= port_ctl_pkg::LATCH_RESET;
      port_c_direction <= port_ctl_pkg::DIRECTION_RESET;
    end else if (reg_wr_i) begin
      // both the pin and latch address write the latch, never pin levels
      if (reg_addr_i == port_ctl_pkg::ADDR_PIN_LEVELS ||
          reg_addr_i == port_ctl_pkg::ADDR_OUT_LATCH) begin
        port_c_output_latch <= reg_wdata_i;
      end
      if (reg_addr_i == port_ctl_pkg::ADDR_DIRECTION) begin
        port_c_direction <= reg_wdata_i;
      end
    end
  end

  // analog select, slew and peripheral control registers, spare bits held at zero
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      analog_select_low <= port_ctl_pkg::ANALOG_LOW_RESET;
      analog_select_high <= port_ctl_pkg::ANALOG_HIGH_RESET;
      slew_rate_control <= port_ctl_pkg::SLEW_RESET;
      periph_ctl <= port_ctl_pkg::PERIPH_RESET;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        port_ctl_pkg::ADDR_ANALOG_LOW: begin
          analog_select_low <= reg_wdata_i & port_ctl_pkg::ANALOG_LOW_MASK;
        end
        port_ctl_pkg::ADDR_ANALOG_HIGH: begin
          analog_select_high <= reg_wdata_i & port_ctl_pkg::ANALOG_HIGH_MASK;
        end
        port_ctl_pkg::ADDR_SLEW: begin
          slew_rate_control <= reg_wdata_i & port_ctl_pkg::SLEW_MASK;
        end
        port_ctl_pkg::ADDR_PERIPH_CTL: begin
          periph_ctl <= reg_wdata_i & port_ctl_pkg::PERIPH_MASK;
        end
        default: begin
        end
      endcase
    end
  end

  // read mux; the pin address shows gated levels, unmapped reads zero
  always_comb begin
    case (reg_addr_i)
      port_ctl_pkg::ADDR_PIN_LEVELS: next_rdata = port_c_pin_levels;
      port_ctl_pkg::ADDR_OUT_LATCH: next_rdata = port_c_output_latch;
      port_ctl_pkg::ADDR_DIRECTION: next_rdata = port_c_direction;
      port_ctl_pkg::ADDR_ANALOG_LOW: next_rdata = analog_select_low;
      port_ctl_pkg::ADDR_ANALOG_HIGH: next_rdata = analog_select_high;
      port_ctl_pkg::ADDR_SLEW: next_rdata = slew_rate_control;
      port_ctl_pkg::ADDR_PERIPH_CTL: next_rdata = periph_ctl;
      default: next_rdata = 8'h00;
    endcase
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      reg_rdata_o <= next_rdata;
    end else begin
      reg_rdata_o <= 8'h00;
    end
  end

  // output drive and overrides; analog select deliberately not used here
  always_comb begin
    next_pad_o = port_c_output_latch;
    next_pad_oe = ~port_c_direction;
    if (!port_c_direction[5]) begin
      if (periph_ctl[port_ctl_pkg::PERIPH_PWM_A_EN_BIT]) begin
        next_pad_o[5] = pwm_channel_a_i;
        // shutdown floats the pin instead of driving a stale level
        if (pwm_shutdown_i) begin
          next_pad_oe[5] = 1'b0;
        end
      end else if (periph_ctl[port_ctl_pkg::PERIPH_COMPARE_EN_BIT]) begin
        next_pad_o[5] = compare_pwm_out_i;
      end
    end
    if (!port_c_direction[7] &&
        periph_ctl[port_ctl_pkg::PERIPH_SERIAL_OUT_EN_BIT]) begin
      next_pad_o[7] = serial_data_out_i;
    end
    // oscillator owns both pins, direction bits ignored
    if (timer_osc_en_i) begin
      next_pad_oe[7:6] = 2'b00;
      next_pad_o[7:6] = 2'b00;
    end
  end

  // registered pin drive
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      port_c_pad_o <= 8'h00;
      port_c_pad_oe_o <= 8'h00;
    end else begin
      port_c_pad_o <= next_pad_o;
      port_c_pad_oe_o <= next_pad_oe;
    end
  end

  // slew selects and peripheral inputs, registered
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      port_a_slow_edges_o <= 1'b1;
      port_b_slow_edges_o <= 1'b1;
      port_c_slow_edges_o <= 1'b1;
      port_a_pin_four_slow_o <= 1'b1;
      port_a_pin_four_in_o <= 1'b0;
      port_b_analog_o <= 2'b11;
      capture_input_o <= 1'b0;
      slave_select_o <= 1'b0;
      secondary_timers_count_input_o <= 1'b0;
      analog_channel_eight_o <= 1'b0;
      analog_channel_nine_o <= 1'b0;
    end else begin
      port_a_slow_edges_o <=
        slew_rate_control[port_ctl_pkg::SLEW_PORT_A_BIT];
      port_b_slow_edges_o <=
        slew_rate_control[port_ctl_pkg::SLEW_PORT_B_BIT];
      port_c_slow_edges_o <=
        slew_rate_control[port_ctl_pkg::SLEW_PORT_C_BIT];
      // clock output needs crisp edges whatever the port setting
      port_a_pin_four_slow_o <= !clock_output_function_i &&
        slew_rate_control[port_ctl_pkg::SLEW_PORT_A_BIT];
      port_a_pin_four_in_o <= pin_four_sync &&
        !analog_select_low[port_ctl_pkg::ANALOG_LOW_PIN_FOUR_BIT];
      port_b_analog_o <= analog_select_high[3:2];
      capture_input_o <= port_c_direction[5] && port_c_pin_levels[5];
      slave_select_o <= port_c_direction[6] && port_c_pin_levels[6];
      secondary_timers_count_input_o <=
        port_c_direction[6] && port_c_pin_levels[6];
      analog_channel_eight_o <= port_c_direction[6] &&
        port_c_analog[6] && !timer_osc_en_i;
      analog_channel_nine_o <= port_c_direction[7] &&
        port_c_analog[7] && !timer_osc_en_i;
    end
  end

  // checks next to the logic
  sequence s_osc_on;
    timer_osc_en_i;
  endsequence

  property p_analog_read_zero;
    @(posedge ref_clk_i) disable iff (!rstn_i)
    reg_rd_i && reg_addr_i == port_ctl_pkg::ADDR_PIN_LEVELS &&
    analog_select_low[4] |=> reg_rdata_o[0] == 1'b0;
  endproperty
  a_analog_read_zero: assert property (p_analog_read_zero)
    else $error("analog pin read not zero");

  property p_drive_latch;
    @(posedge ref_clk_i) disable iff (!rstn_i)
    !port_c_direction[0] |=> port_c_pad_oe_o[0] &&
      port_c_pad_o[0] == $past(port_c_output_latch[0]);
  endproperty
  a_drive_latch: assert property (p_drive_latch)
    else $error("output not driven from latch");

  property p_dir_off;
    @(posedge ref_clk_i) disable iff (!rstn_i)
    port_c_direction[3] |=> !port_c_pad_oe_o[3];
  endproperty
  a_dir_off: assert property (p_dir_off)
    else $error("driver on while direction is input");

  property p_slew_wr;
    @(posedge ref_clk_i) disable iff (!rstn_i)
    reg_wr_i && reg_addr_i == port_ctl_pkg::ADDR_SLEW |=> ##1
      port_c_slow_edges_o == $past(reg_wdata_i[2], 2);
  endproperty
  a_slew_wr: assert property (p_slew_wr)
    else $error("port c slew output wrong after write");

  property p_clock_output_function_fast;
    @(posedge ref_clk_i) disable iff (!rstn_i)
    clock_output_function_i |=> !port_a_pin_four_slow_o;
  endproperty
  a_clock_output_function_fast: assert property (p_clock_output_function_fast)
    else $error("clock output pin slow");

  property p_osc_pins;
    @(posedge ref_clk_i) disable iff (!rstn_i)
    s_osc_on |=> port_c_pad_oe_o[7:6] == 2'b00;
  endproperty
  a_osc_pins: assert property (p_osc_pins)
    else $error("oscillator pins driven");

  property p_sdo;
    @(posedge ref_clk_i) disable iff (!rstn_i)
    !port_c_direction[7] && periph_ctl[1] && !timer_osc_en_i |=>
      port_c_pad_o[7] == $past(serial_data_out_i);
  endproperty
  a_sdo: assert property (p_sdo)
    else $error("serial data out not on pin");

  property p_shutdown;
    @(posedge ref_clk_i) disable iff (!rstn_i)
    periph_ctl[2] && pwm_shutdown_i |=> !port_c_pad_oe_o[5];
  endproperty
  a_shutdown: assert property (p_shutdown)
    else $error("pwm pin driven during shutdown");

  property p_rd_gap;
    @(posedge ref_clk_i) disable iff (!rstn_i)
    !reg_rd_i |=> reg_rdata_o == 8'h00;
  endproperty
  a_rd_gap: assert property (p_rd_gap)
    else $error("read data outside read cycle");
endmodule
`default_nettype wire

// ==== verification/port_pin_control_tb.sv ====
// self-checking bench for the port c analog, slew and override block
`timescale 1ns/1ps
`default_nettype none
module port_pin_control_tb;
  logic ref_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [3:0] reg_addr_i = 4'h0;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [7:0] reg_rdata_o;
  logic [7:0] port_c_pad_i = 8'hFF;
  logic [7:0] port_c_pad_o;
  logic [7:0] port_c_pad_oe_o;
  logic port_a_pin_four_pad_i = 1'b1;
  logic clock_output_function_i = 1'b0;
  logic timer_osc_en_i = 1'b0;
  logic compare_pwm_out_i = 1'b0;
  logic pwm_channel_a_i = 1'b0;
  logic pwm_shutdown_i = 1'b0;
  logic serial_data_out_i = 1'b0;
  logic port_c_slow_edges_o, port_a_pin_four_in_o, port_a_slow_edges_o;
  logic port_a_pin_four_slow_o, port_b_slow_edges_o;
  logic [1:0] port_b_analog_o;
  logic capture_input_o, slave_select_o, secondary_timers_count_input_o;
  logic analog_channel_eight_o, analog_channel_nine_o;
  int fails = 0;
  int comparisons = 0;

  port_pin_control dut (
    .ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .port_c_pad_i(port_c_pad_i), .port_c_pad_o(port_c_pad_o),
    .port_c_pad_oe_o(port_c_pad_oe_o),
    .port_c_slow_edges_o(port_c_slow_edges_o),
    .port_a_pin_four_pad_i(port_a_pin_four_pad_i),
    .port_a_pin_four_in_o(port_a_pin_four_in_o),
    .port_a_slow_edges_o(port_a_slow_edges_o),
    .port_a_pin_four_slow_o(port_a_pin_four_slow_o),
    .port_b_slow_edges_o(port_b_slow_edges_o),
    .port_b_analog_o(port_b_analog_o),
    .clock_output_function_i(clock_output_function_i),
    .timer_osc_en_i(timer_osc_en_i),
    .compare_pwm_out_i(compare_pwm_out_i),
    .pwm_channel_a_i(pwm_channel_a_i), .pwm_shutdown_i(pwm_shutdown_i),
    .serial_data_out_i(serial_data_out_i),
    .capture_input_o(capture_input_o), .slave_select_o(slave_select_o),
    .secondary_timers_count_input_o(secondary_timers_count_input_o),
    .analog_channel_eight_o(analog_channel_eight_o),
    .analog_channel_nine_o(analog_channel_nine_o)
  );

  // 200 MHz core clock
  initial begin
    forever #2.5 ref_clk_i = ~ref_clk_i;
  end

  // compare and count; an unknown never matches
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t mismatch seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one-cycle write strobe, taken at the edge that lowers it
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b0;
    #1;
    check(reg_rdata_o, exp);
  endtask

  // let registered outputs land, sample away from the edge
  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask

  task automatic summarize();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // the sequence needs well under two thousand cycles
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    fails++;
    summarize();
  end

  initial begin
    repeat (20) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    wt(2);
    // reset values and unmapped address
    rd_chk(port_ctl_pkg::ADDR_ANALOG_LOW, 8'hF8);
    rd_chk(port_ctl_pkg::ADDR_ANALOG_HIGH, 8'h0F);
    rd_chk(port_ctl_pkg::ADDR_SLEW, 8'h07);
    rd_chk(port_ctl_pkg::ADDR_DIRECTION, 8'hFF);
    rd_chk(4'h7, 8'h00);
    check({5'h0, port_c_slow_edges_o, port_b_slow_edges_o,
           port_a_slow_edges_o}, 8'h07);
    check(8'(port_b_analog_o), 8'h03);
    check(8'(port_a_pin_four_in_o), 8'h00);
    // analog pins read zero while the pads sit high
    rd_chk(port_ctl_pkg::ADDR_PIN_LEVELS, 8'h30);
    wr(port_ctl_pkg::ADDR_ANALOG_LOW, 8'hFF);
    rd_chk(port_ctl_pkg::ADDR_ANALOG_LOW, 8'hF8);
    wr(port_ctl_pkg::ADDR_ANALOG_LOW, 8'h08);
    rd_chk(port_ctl_pkg::ADDR_PIN_LEVELS, 8'h3F);
    wr(port_ctl_pkg::ADDR_ANALOG_LOW, 8'h80);
    rd_chk(port_ctl_pkg::ADDR_PIN_LEVELS, 8'h37);
    wt(2);
    check(8'(port_a_pin_four_in_o), 8'h01);
    wr(port_ctl_pkg::ADDR_ANALOG_HIGH, 8'hF4);
    rd_chk(port_ctl_pkg::ADDR_ANALOG_HIGH, 8'h04);
    rd_chk(port_ctl_pkg::ADDR_PIN_LEVELS, 8'hF7);
    check(8'(port_b_analog_o), 8'h01);
    wr(port_ctl_pkg::ADDR_ANALOG_HIGH, 8'h02);
    rd_chk(port_ctl_pkg::ADDR_PIN_LEVELS, 8'h77);
    wr(port_ctl_pkg::ADDR_ANALOG_HIGH, 8'h09);
    rd_chk(port_ctl_pkg::ADDR_PIN_LEVELS, 8'hB7);
    check(8'(port_b_analog_o), 8'h02);
    // slew bits, one per port; clock output forces standard rate
    wr(port_ctl_pkg::ADDR_SLEW, 8'hFA);
    rd_chk(port_ctl_pkg::ADDR_SLEW, 8'h02);
    check({5'h0, port_c_slow_edges_o, port_b_slow_edges_o,
           port_a_slow_edges_o}, 8'h02);
    wr(port_ctl_pkg::ADDR_SLEW, 8'h05);
    wt(2);
    check({4'h0, port_c_slow_edges_o, port_b_slow_edges_o,
           port_a_slow_edges_o, port_a_pin_four_slow_o}, 8'h0B);
    @(posedge ref_clk_i) clock_output_function_i <= 1'b1;
    wt(2);
    check(8'(port_a_pin_four_slow_o), 8'h00);
    // output drive untouched by analog select
    wr(port_ctl_pkg::ADDR_ANALOG_LOW, 8'hF8);
    wr(port_ctl_pkg::ADDR_ANALOG_HIGH, 8'h0F);
    wr(port_ctl_pkg::ADDR_OUT_LATCH, 8'hA5);
    wr(port_ctl_pkg::ADDR_DIRECTION, 8'h00);
    wt(2);
    check(port_c_pad_oe_o, 8'hFF);
    check(port_c_pad_o, 8'hA5);
    rd_chk(port_ctl_pkg::ADDR_OUT_LATCH, 8'hA5);
    wr(port_ctl_pkg::ADDR_PIN_LEVELS, 8'h1C);
    rd_chk(port_ctl_pkg::ADDR_OUT_LATCH, 8'h1C);
    // compare output, then pwm channel a, on rc5
    wr(port_ctl_pkg::ADDR_PERIPH_CTL, 8'h01);
    @(posedge ref_clk_i) compare_pwm_out_i <= 1'b1;
    wt(2);
    check(port_c_pad_o, 8'h3C);
    wr(port_ctl_pkg::ADDR_PERIPH_CTL, 8'h05);
    @(posedge ref_clk_i) compare_pwm_out_i <= 1'b0;
    pwm_channel_a_i <= 1'b1;
    wt(2);
    check(port_c_pad_o, 8'h3C);
    @(posedge ref_clk_i) pwm_shutdown_i <= 1'b1;
    wt(2);
    check(port_c_pad_oe_o, 8'hDF);
    // serial data out on rc7, then the oscillator takes rc7:6
    wr(port_ctl_pkg::ADDR_PERIPH_CTL, 8'h02);
    @(posedge ref_clk_i) serial_data_out_i <= 1'b1;
    pwm_shutdown_i <= 1'b0;
    wt(2);
    check(port_c_pad_o, 8'h9C);
    rd_chk(port_ctl_pkg::ADDR_PERIPH_CTL, 8'h02);
    @(posedge ref_clk_i) timer_osc_en_i <= 1'b1;
    wt(2);
    check({4'h0, port_c_pad_oe_o[7:6], port_c_pad_o[7:6]},
          8'h00);
    wr(port_ctl_pkg::ADDR_DIRECTION, 8'hFF);
    wr(port_ctl_pkg::ADDR_ANALOG_HIGH, 8'h00);
    wr(port_ctl_pkg::ADDR_ANALOG_LOW, 8'h00);
    rd_chk(port_ctl_pkg::ADDR_PIN_LEVELS, 8'h3F);
    @(posedge ref_clk_i) timer_osc_en_i <= 1'b0;
    wt(2);
    rd_chk(port_ctl_pkg::ADDR_PIN_LEVELS, 8'hFF);
    // inputs feed capture, slave select and the timers' count
    check({5'h00, capture_input_o, slave_select_o,
           secondary_timers_count_input_o}, 8'h07);
    @(posedge ref_clk_i) port_c_pad_i <= 8'h9F;
    wt(4);
    check({5'h00, capture_input_o, slave_select_o,
           secondary_timers_count_input_o}, 8'h00);
    wr(port_ctl_pkg::ADDR_ANALOG_HIGH, 8'h03);
    wt(2);
    check({6'h00, analog_channel_nine_o,
           analog_channel_eight_o}, 8'h03);
    @(posedge ref_clk_i) timer_osc_en_i <= 1'b1;
    wt(2);
    check({6'h00, analog_channel_nine_o,
           analog_channel_eight_o}, 8'h00);
    // a second reset restores the select and slew bits
    @(posedge ref_clk_i) rstn_i <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    rd_chk(port_ctl_pkg::ADDR_SLEW, 8'h07);
    rd_chk(port_ctl_pkg::ADDR_ANALOG_HIGH, 8'h0F);
    summarize();
  end
endmodule
`default_nettype wire
